// ---- hw/adh_dryer_handshake.sv ----
`timescale 1ns/1ns
module adh_dryer_handshake (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Batch supplied by the host, per channel
	input wire logic [adh_pkg::ADH_NCH*adh_pkg::ADH_CODE_W-1:0] batch_code,
	input wire logic [adh_pkg::ADH_NCH-1:0] batch_partial,
	input wire logic [adh_pkg::ADH_NCH-1:0] batch_ready,
	input wire logic [adh_pkg::ADH_NCH-1:0] conveyor_ready,
	// Handshake inputs from the dryers
	input wire logic [adh_pkg::ADH_NCH-1:0] load_request,
	input wire logic [adh_pkg::ADH_NCH-1:0] load_door_open,
	input wire logic [adh_pkg::ADH_NCH-1:0] load_door_closed,
	input wire logic [adh_pkg::ADH_NCH-1:0] discharge_request,
	input wire logic [adh_pkg::ADH_NCH-1:0] discharge_door_open,
	input wire logic [adh_pkg::ADH_NCH-1:0] discharge_door_closed,
	// Handshake and batch outputs to the dryers
	output logic [adh_pkg::ADH_NCH-1:0] load_permit,
	output logic [adh_pkg::ADH_NCH-1:0] loaded,
	output logic [adh_pkg::ADH_NCH*adh_pkg::ADH_CODE_W-1:0] dry_program_code,
	output logic [adh_pkg::ADH_NCH-1:0] partial_load,
	output logic [adh_pkg::ADH_NCH-1:0] discharge_permit,
	// Events back to the host
	output logic [adh_pkg::ADH_NCH-1:0] load_done,
	output logic [adh_pkg::ADH_NCH-1:0] discharge_done
);
	import adh_pkg::*;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// The dryers are outside equipment; the first stage is read only by the second.
	localparam int NIN = 6;
	logic [NIN*ADH_NCH-1:0] raw;
	logic [NIN*ADH_NCH-1:0] s1_q, s1_d, s2_q, s2_d;

	assign raw = {discharge_door_closed, discharge_door_open, discharge_request,
		load_door_closed, load_door_open, load_request};

	always_comb begin
		s1_d = raw; // RL13
		s2_d = s1_q; // RL13
		if (!resetn) begin
			s1_d = '0;
			s2_d = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		s1_q <= s1_d;
		s2_q <= s2_d;
	end

	// ----------------------------------------------------------------
	// Per-channel handshake sequencer
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < ADH_NCH; g = g + 1) begin : g_ch // RL12
			logic req_l, door_o, door_c, req_d, ddoor_o, ddoor_c;
			adh_state_t st_q, st_d;
			logic [ADH_CODE_W-1:0] code_q, code_d;
			logic part_q, part_d, lp_q, lp_d, ld_q, ld_d, dp_q, dp_d;
			logic ldone_q, ldone_d, ddone_q, ddone_d;

			assign req_l = s2_q[0*ADH_NCH+g];
			assign door_o = s2_q[1*ADH_NCH+g];
			assign door_c = s2_q[2*ADH_NCH+g];
			assign req_d = s2_q[3*ADH_NCH+g];
			assign ddoor_o = s2_q[4*ADH_NCH+g];
			assign ddoor_c = s2_q[5*ADH_NCH+g];

			always_comb begin
				st_d = st_q;
				code_d = code_q;
				part_d = part_q;
				lp_d = lp_q;
				ld_d = ld_q;
				dp_d = dp_q;
				ldone_d = 1'b0;
				ddone_d = 1'b0;
				case (st_q) // RL4
					ADH_IDLE: begin
						// Permission waits for the host to have a batch staged.
						if (req_l && batch_ready[g]) begin
							lp_d = 1'b1; // RL5
							st_d = ADH_LOAD_OK;
						end
					end
					ADH_LOAD_OK: begin
						if (door_o) begin
							// Bit 0 of each code slice is signal A. RL1 RL3
							code_d = batch_code[g*ADH_CODE_W +: ADH_CODE_W]; // RL6
							part_d = batch_partial[g]; // RL9
							st_d = ADH_LOADING;
						end
					end
					ADH_LOADING: begin
						// Data settled a cycle earlier, so the strobe trails it.
						ld_d = 1'b1; // RL7
						st_d = ADH_LOADED;
					end
					ADH_LOADED: begin
						if (door_c) begin
							code_d = ADH_CODE_RST; // RL8
							part_d = ADH_FLAG_RST; // RL8
							ld_d = 1'b0;
							lp_d = 1'b0;
							ldone_d = 1'b1;
							st_d = ADH_DRYING;
						end
					end
					ADH_DRYING: begin
						if (req_d && conveyor_ready[g]) begin
							dp_d = 1'b1; // RL10
							st_d = ADH_DIS_OK;
						end
					end
					ADH_DIS_OK: begin
						if (ddoor_o) begin
							st_d = ADH_DISCH; // RL11
						end
					end
					ADH_DISCH: begin
						if (ddoor_c && !ddoor_o) begin
							dp_d = 1'b0; // RL11
							ddone_d = 1'b1;
							st_d = ADH_IDLE;
						end
					end
					default: begin
						st_d = ADH_IDLE;
					end
				endcase
				if (!resetn) begin
					st_d = ADH_IDLE; // RL14
					code_d = ADH_CODE_RST;
					part_d = ADH_FLAG_RST;
					lp_d = 1'b0;
					ld_d = 1'b0;
					dp_d = 1'b0;
					ldone_d = 1'b0;
					ddone_d = 1'b0;
				end
			end

			always_ff @(posedge ref_clk) begin
				st_q <= st_d;
				code_q <= code_d;
				part_q <= part_d;
				lp_q <= lp_d;
				ld_q <= ld_d;
				dp_q <= dp_d;
				ldone_q <= ldone_d;
				ddone_q <= ddone_d;
			end

			assign dry_program_code[g*ADH_CODE_W +: ADH_CODE_W] = code_q;
			assign partial_load[g] = part_q;
			assign load_permit[g] = lp_q;
			assign loaded[g] = ld_q;
			assign discharge_permit[g] = dp_q;
			assign load_done[g] = ldone_q;
			assign discharge_done[g] = ddone_q;
		end
	endgenerate

endmodule : adh_dryer_handshake

// ---- hw/adh_pkg.sv ----
// Behaviour
// RL1: Program code is 4 bits, bit 0 least significant, selecting one of 16.
// RL2: Dryer may sample code bits in any order while data is valid.
// RL3: Both ends use the same bit significance on the code wires.
// RL4: Handshake runs load request through load door closed, then discharge steps.
// RL5: Dryer raises load request; device answers with load permission.
// RL6: On load door open, device drives program code and partial-load flag.
// RL7: Device raises loaded indication; dryer reads batch data after it.
// RL8: On load door closed, device clears all batch data outputs.
// RL9: Partial-load flag marks a single-cake batch and is batch data.
// RL10: Dryer raises discharge request; device answers with discharge permission.
// RL11: Dryer reports discharge door open, then discharge door closed.
// RL12: Eight independent dryer channels, indexed 0 through 7.
// RL13: Every handshake input passes a two-stage synchroniser before use.
// RL14: Reset clears all outputs and returns each channel to await a load request.
package adh_pkg;

	localparam int ADH_NCH = 8;
	localparam int ADH_CODE_W = 4;
	localparam logic [ADH_CODE_W-1:0] ADH_CODE_RST = 4'h0;
	localparam logic ADH_FLAG_RST = 1'h0;

	typedef enum logic [2:0] {
		ADH_IDLE,
		ADH_LOAD_OK,
		ADH_LOADING,
		ADH_LOADED,
		ADH_DRYING,
		ADH_DIS_OK,
		ADH_DISCH
	} adh_state_t;

endpackage : adh_pkg

// ---- tb/adh_checker.sv ----
`timescale 1ns/1ns
module adh_checker (
	input wire logic ref_clk, resetn,
	input wire logic [7:0] load_request, load_door_closed, load_permit, loaded,
	input wire logic [7:0] partial_load, discharge_permit, load_done, discharge_done,
	input wire logic [31:0] dry_program_code
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	reset_clear_a: assert property (disable iff (1'h0)
		!resetn |=> !(|{load_permit, loaded, partial_load, dry_program_code}))
		else $error("outputs live in reset");
	permit_answer_a: assert property ($rose(load_permit[0])
		|-> $past(load_request[0], 2)) else $error("permit without request");
	loaded_valid_a: assert property ($rose(loaded[0])
		|-> $past(load_permit[0]) && $stable(dry_program_code[3:0])) else $error("early strobe");
	data_hold_a: assert property (loaded[0] && $past(loaded[0])
		|-> $stable(dry_program_code[3:0]) && $stable(partial_load[0])) else $error("data moved");
	idle_zero_a: assert property (!load_permit[0]
		|-> !dry_program_code[3:0] && !partial_load[0] && !loaded[0]) else $error("data left");
	close_clear_a: assert property (load_door_closed[0] && loaded[0]
		|-> ##[1:4] !loaded[0]) else $error("strobe stuck");
	done_pulse_a: assert property (load_done[0] |=> !load_done[0])
		else $error("long done");
	dis_done_a: assert property (discharge_done[0] |-> $fell(discharge_permit[0]))
		else $error("done without drop");
	cover property ($rose(loaded[0]));
	cover property ($fell(load_permit[0]));
	cover property (discharge_done[0]);
endmodule : adh_checker

// ---- tb/adh_dryer_model.sv ----
`timescale 1ns/1ns
module adh_dryer_model (
	input wire logic ref_clk, go, lp, ld, dp, pl,
	input wire logic [3:0] lag, cd,
	output logic lr, lo, lc, dr, dop, dc, fin,
	output logic [4:0] got
);
	initial begin
		{lr, lo, lc, dr, dop, dc, fin, got} = 0;
		forever begin
			do @(posedge ref_clk); while (!go);
			lr <= 1'h1;
			do @(posedge ref_clk); while (!lp);
			repeat (lag + 1) @(posedge ref_clk);
			lo <= 1'h1;
			do @(posedge ref_clk); while (!ld);
			got <= {pl, cd};
			{lr, lo, lc} <= 3'h1;
			do @(posedge ref_clk); while (lp);
			{lc, dr} <= 2'h1;
			do @(posedge ref_clk); while (!dp);
			{dr, dop} <= 2'h1;
			repeat (lag + 1) @(posedge ref_clk);
			{dop, dc} <= 2'h1;
			do @(posedge ref_clk); while (dp);
			{dc, fin} <= 2'h1;
			@(posedge ref_clk);
			fin <= 1'h0;
		end
	end
endmodule : adh_dryer_model

// ---- tb/allied_dryer_handshake_bench.sv ----
`timescale 1ns/1ns
module allied_dryer_handshake_bench;
	logic ref_clk = 0, resetn = 0;
	logic [31:0] code = 0;
	logic [7:0] pb = 0, br = 0, cr = 0, go = 0;
	wire [31:0] dpc;
	wire [7:0] lr, lo, lc, dr, dop, dc, fin, lp, ld, pl, dp, ldn, ddn;
	wire [4:0] got [8];
	int mismatches = 0, compares = 0;
	adh_dryer_handshake dut (.ref_clk, .resetn, .batch_code(code), .batch_partial(pb),
		.batch_ready(br), .conveyor_ready(cr), .load_request(lr), .load_door_open(lo),
		.load_door_closed(lc), .discharge_request(dr), .discharge_door_open(dop),
		.discharge_door_closed(dc), .load_permit(lp), .loaded(ld), .dry_program_code(dpc),
		.partial_load(pl), .discharge_permit(dp), .load_done(ldn), .discharge_done(ddn));
	for (genvar g = 0; g < 8; g++) begin : ch
		adh_dryer_model m (.ref_clk, .go(go[g]), .lp(lp[g]), .ld(ld[g]), .dp(dp[g]),
			.pl(pl[g]), .lag(4'(g)), .cd(dpc[4*g+:4]), .lr(lr[g]), .lo(lo[g]), .lc(lc[g]),
			.dr(dr[g]), .dop(dop[g]), .dc(dc[g]), .fin(fin[g]), .got(got[g]));
	end
	initial forever #50 ref_clk = ~ref_clk;
	task automatic chk(input string n, input logic [4:0] e, s);
		compares++;
		if (e !== s) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic run(input logic [7:0] m);
		logic [7:0] seen, lseen, dseen;
		seen = 0;
		lseen = 0;
		dseen = 0;
		for (int i = 0; i < 300 && seen !== m; i++) begin
			@(posedge ref_clk);
			go <= 8'h00;
			seen |= fin & m;
			lseen |= ldn & m;
			dseen |= ddn & m;
		end
		compares++;
		if (lseen !== m || dseen !== m) begin
			mismatches++;
			$display("wrong value done expected %h seen %h %h", m, lseen, dseen);
		end
		if (seen !== m) begin
			mismatches++;
			$display("wrong value finish expected %h seen %h", m, seen);
			conclude();
		end
	endtask : run
	task automatic t_codes(input logic r);
		for (int g = 0; g < 8; g++) begin
			code[4*g+:4] <= {r, 3'(g)};
			pb[g] <= r ^ g[0];
		end
		{br, cr, go} <= {3{8'hFF}};
		run(8'hFF);
		for (int g = 0; g < 8; g++) chk("code", {r ^ g[0], r, 3'(g)}, got[g]);
		chk("cleared", 5'h00, {|pl, 4'(|dpc)});
		$display("codes round %0d done", r);
	endtask : t_codes
	task automatic t_gate();
		{br, go} <= 16'h0001;
		repeat (10) @(posedge ref_clk);
		chk("permit", 5'h00, {4'h0, lp[0]});
		br <= 8'hFF;
		run(8'h01);
		$display("gate done");
	endtask : t_gate
	task automatic t_reset();
		go <= 8'h02;
		for (int i = 0; i < 100 && ld[1] !== 1'h1; i++) @(posedge ref_clk);
		chk("strobe", 5'h01, {4'h0, ld[1]});
		resetn <= 1'h0;
		repeat (3) @(posedge ref_clk);
		chk("reset", 5'h00, {|lp, |ld, |pl, |dp, |dpc});
		$display("reset done");
	endtask : t_reset
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : conclude
	initial begin
		repeat (8) @(posedge ref_clk);
		resetn <= 1'h1;
		repeat (2) @(posedge ref_clk);
		t_codes(0);
		t_codes(1);
		t_gate();
		t_reset();
		conclude();
	end
endmodule : allied_dryer_handshake_bench
bind adh_dryer_handshake adh_checker chk_u (.ref_clk, .resetn, .load_request,
	.load_door_closed, .load_permit, .loaded, .partial_load, .discharge_permit,
	.load_done, .discharge_done, .dry_program_code);
